// ===== bench/tb.sv
// self-checking bench for the table unit
// assumes: unit, header, checker and memory model compiled first
// ****
// bench top
// ****
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 0, rst = 1, clk_en = 1, instr_valid = 0, ptr_wr_en = 0, latch_wr_en = 0;
    logic [1:0]  q_phase = 0;
    logic [2:0]  hold_rd_sel = 0;
    logic [15:0] instr_word = 0, pm_rdata;
    logic [20:0] ptr_wr_data = 0, e_ptr = 0, byte_pointer;
    logic [7:0]  latch_wr_data = 0, e_lat = 0, hold_rd_data, table_latch, e_hold [0:7];
    logic [19:0] pm_word_addr;
    logic        pm_rd_en, busy, op_done;
    integer      n_mismatch = 0, cmp_count = 0, i, k;
    trw_unit u_dut (.mclk(mclk), .rst(rst), .clk_en(clk_en), .q_phase(q_phase), .instr_valid(instr_valid),
        .instr_word(instr_word), .ptr_wr_en(ptr_wr_en), .ptr_wr_data(ptr_wr_data), .latch_wr_en(latch_wr_en),
        .latch_wr_data(latch_wr_data), .pm_rd_en(pm_rd_en), .pm_word_addr(pm_word_addr), .pm_rdata(pm_rdata),
        .hold_rd_sel(hold_rd_sel), .hold_rd_data(hold_rd_data), .byte_pointer(byte_pointer),
        .table_latch(table_latch), .busy(busy), .op_done(op_done));
    trw_pm_model u_pm (.mclk(mclk), .pm_rd_en(pm_rd_en), .pm_word_addr(pm_word_addr), .pm_rdata(pm_rdata));
    // clock, and the core phase stepping once a clock
    always #50 mclk = ~mclk;
    // phase runs free from time zero, so releasing reset never races the phase step
    always @(negedge mclk) q_phase <= q_phase + 2'h1;
    // byte the memory model holds at a byte address
    function automatic [7:0] mem_byte(input [20:0] p);
        mem_byte = p[0] ? p[8:1] ^ p[20:13] : p[8:1] ^ 8'h3c;
    endfunction
    task chk(input [31:0] seen, input [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task summarize;
        if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // core load of pointer and latch while idle
    task ld(input [20:0] p, input [7:0] l);
        ptr_wr_en = 1;
        latch_wr_en = 1;
        ptr_wr_data = p;
        latch_wr_data = l;
        @(negedge mclk);
        ptr_wr_en = 0;
        latch_wr_en = 0;
        e_ptr = p;
        e_lat = l;
    endtask
    task hold_chk;
        integer j;
        for (j = 0; j < 8; j++) begin
            hold_rd_sel = j[2:0];
            @(negedge mclk);
            chk(hold_rd_data, e_hold[j]);
        end
    endtask
    // offer a word at Q1; loads and the offer stay up while busy and must be ignored
    task op(input [15:0] w);
        integer t;
        repeat (4) if (q_phase !== 2'h3) @(negedge mclk);
        instr_valid = 1;
        instr_word = w;
        @(negedge mclk);
        if (w[15:3] != 13'h0001) begin
            instr_valid = 0;
            chk(busy, 0);
        end else begin
            if (w[1:0] == 2'h3) e_ptr = e_ptr + 21'h1;
            if (w[2]) e_hold[e_ptr[2:0]] = e_lat;
            else e_lat = mem_byte(e_ptr);
            e_ptr = w[1:0] == 2'h1 ? e_ptr + 21'h1 : w[1:0] == 2'h2 ? e_ptr - 21'h1 : e_ptr;
            ptr_wr_en = 1;
            latch_wr_en = 1;
            ptr_wr_data = 21'($urandom);
            latch_wr_data = 8'($urandom);
            for (t = 1; t < 12 && op_done !== 1'b1; t++) @(negedge mclk);
            instr_valid = 0;
            ptr_wr_en = 0;
            latch_wr_en = 0;
            chk(t, 8);
            chk(byte_pointer, e_ptr);
            chk(table_latch, e_lat);
            if (t == 12) summarize;
        end
    endtask
    // reset, wrap corners, refused opcodes, every mode, then random traffic
    initial begin
        k = $urandom(32'h876af44d);
        for (k = 0; k < 8; k++) e_hold[k] = 8'hff;
        repeat (5) @(negedge mclk);
        rst = 0;
        chk(byte_pointer, 0);
        chk(table_latch, 0);
        // a core load while clk_en is low must leave pointer and latch frozen
        clk_en = 0;
        ptr_wr_en = 1;
        latch_wr_en = 1;
        ptr_wr_data = 21'h0abcde;
        latch_wr_data = 8'h3c;
        repeat (2) @(negedge mclk);
        ptr_wr_en = 0;
        latch_wr_en = 0;
        clk_en = 1;
        chk(byte_pointer, 0);
        chk(table_latch, 0);
        hold_chk;
        ld(21'h1fffff, 8'h55);
        op(16'h000d);
        ld(21'h000000, 8'ha5);
        op(16'h000a);
        op(16'h0007);
        op(16'h0010);
        op(16'h4008);
        for (i = 0; i < 40; i++) begin
            k = $urandom;
            if (i < 8 || k[4]) ld(k[31:11], k[10:3]);
            op({13'h0001, i < 8 ? i[2:0] : k[2:0]});
            hold_chk;
        end
        summarize;
    end
endmodule

// ===== bench/trw_pm_model.sv
// program memory stand-in for the table unit
// assumes: same clock, word answered one clock after the request
// ****
// memory model
// ****
module trw_pm_model (
    // request
    input  logic        mclk,
    input  logic        pm_rd_en,
    input  logic [19:0] pm_word_addr,
    // answer
    output logic [15:0] pm_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pm_rdata = 16'h0000;
    // read-only array, valid word one clock after request, changing junk otherwise
    always @(posedge mclk) begin
        pm_rdata <= pm_rd_en ? {pm_word_addr[7:0] ^ pm_word_addr[19:12], pm_word_addr[7:0] ^ 8'h3c}
                             : ~pm_rdata;
    end
endmodule

// ===== bench/trw_unit_chk.sv
// port checker for the table unit
// assumes: bound to trw_unit, q_phase steps every clock, clk_en high while an op runs
// ****
// checker
// ****
module trw_unit_chk #(parameter PTR_W = 21) (
    input logic             mclk,
    input logic             rst,
    input logic             clk_en,
    input logic [1:0]       q_phase,
    input logic             instr_valid,
    input logic [15:0]      instr_word,
    input logic             ptr_wr_en,
    input logic             latch_wr_en,
    input logic             pm_rd_en,
    input logic [PTR_W-2:0] pm_word_addr,
    input logic [15:0]      pm_rdata,
    input logic [PTR_W-1:0] byte_pointer,
    input logic [7:0]       table_latch,
    input logic             busy,
    input logic             op_done
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // instruction taken with no core load alongside
    wire tk = clk_en && q_phase == 2'h0 && instr_valid && instr_word[15:3] == 13'h0001 && !busy
              && !ptr_wr_en && !latch_wr_en;
    wire [1:0] md = instr_word[1:0];
    sequence s_busy;
        busy [*7];
    endsequence
    sequence s_fetch;
        (!pm_rd_en) [*4] ##1 pm_rd_en ##1 !pm_rd_en;
    endsequence
    property p_load;
        logic b;
        logic [15:0] d;
        (pm_rd_en, b = byte_pointer[0]) ##1 (1'b1, d = pm_rdata) |-> ##2 table_latch == (b ? d[15:8] : d[7:0]);
    endproperty
    AST_TIMING: assert property (tk |-> ##1 s_busy ##1 (op_done && !busy)) else $error("bad op timing");
    AST_RD_FETCH: assert property (tk && !instr_word[2] |-> ##1 s_fetch) else $error("bad fetch");
    AST_WR_NOFETCH: assert property (tk && instr_word[2] |-> ##1 (!pm_rd_en) [*8]) else $error("write fetch");
    AST_PTR_KEEP: assert property (tk && md == 2'h0 |-> ##8 byte_pointer == $past(byte_pointer, 8))
        else $error("pointer moved");
    AST_POST_INC: assert property (tk && md == 2'h1 |-> ##4 byte_pointer == $past(byte_pointer, 4)
        ##4 byte_pointer == $past(byte_pointer, 8) + 1'b1) else $error("bad post inc");
    AST_POST_DEC: assert property (tk && md == 2'h2 |-> ##8 byte_pointer == $past(byte_pointer, 8) - 1'b1)
        else $error("bad post dec");
    AST_PRE_INC: assert property (tk && md == 2'h3 |-> ##4 byte_pointer == $past(byte_pointer, 4) + 1'b1
        ##4 byte_pointer == $past(byte_pointer, 4)) else $error("bad pre inc");
    AST_LATCH_LOAD: assert property (p_load) else $error("bad latch byte");
    AST_ADDR: assert property (pm_rd_en |-> pm_word_addr == byte_pointer[PTR_W-1:1])
        else $error("bad word address");
endmodule
bind trw_unit trw_unit_chk #(.PTR_W(PTR_W)) u_chk (.mclk(mclk), .rst(rst), .clk_en(clk_en), .q_phase(q_phase),
    .instr_valid(instr_valid), .instr_word(instr_word), .ptr_wr_en(ptr_wr_en), .latch_wr_en(latch_wr_en),
    .pm_rd_en(pm_rd_en), .pm_word_addr(pm_word_addr), .pm_rdata(pm_rdata), .byte_pointer(byte_pointer),
    .table_latch(table_latch), .busy(busy), .op_done(op_done));

// ===== common/trw_map.vh
// constants for the table read / table write unit
// assumes: included by bare name from every design file of the unit
`ifndef TRW_MAP_VH
`define TRW_MAP_VH

// ****************************************
// opcode layout
// ****************************************
`define TRW_OPC_HI_W      14
`define TRW_OPC_RD_HI     14'h0002
`define TRW_OPC_WR_HI     14'h0003

// ****************************************
// step mode field codes
// ****************************************
`define TRW_STEP_NONE     2'h0
`define TRW_STEP_POST_INC 2'h1
`define TRW_STEP_POST_DEC 2'h2
`define TRW_STEP_PRE_INC  2'h3

// ****************************************
// instruction cycle phases
// ****************************************
`define TRW_Q1            2'h0
`define TRW_Q2            2'h1
`define TRW_Q3            2'h2
`define TRW_Q4            2'h3

// ****************************************
// widths and reset values
// ****************************************
`define TRW_PTR_W         21
`define TRW_PTR_RESET     21'h000000
`define TRW_LATCH_RESET   8'h00
`define TRW_HOLD_RESET    8'hff
`define TRW_HOLD_DEPTH    8
`define TRW_HOLD_SEL_W    3

`endif

// ===== hdl/trw_hold_bank.v
// bank of holding registers that stage bytes for later flash programming
// assumes: one clock, synchronous active-high reset, writes come from trw_unit
`include "trw_map.vh"

module trw_hold_bank #(
    parameter DEPTH = `TRW_HOLD_DEPTH,
    parameter SEL_W = `TRW_HOLD_SEL_W
) (
    // clock and reset
    input  wire             mclk,
    input  wire             rst,
    input  wire             clk_en,
    // write port from the table write path
    input  wire             wr_en,
    input  wire [SEL_W-1:0] wr_sel,
    input  wire [7:0]       wr_data,
    // read port for the programming sequencer
    input  wire [SEL_W-1:0] rd_sel,
    output reg  [7:0]       rd_data
);

    wire [8*DEPTH-1:0] flat;

    // ****************************************
    // one byte register per entry
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
            reg [7:0] byte_reg;
            // only the entry picked by the pointer low bits is loaded
            always @(posedge mclk) begin
                if (rst) begin
                    byte_reg <= `TRW_HOLD_RESET;
                end else if (clk_en && wr_en && (wr_sel == i)) begin
                    byte_reg <= wr_data;
                end
            end
            assign flat[8*i +: 8] = byte_reg;
        end
    endgenerate

    // ****************************************
    // registered read-out
    // ****************************************
    // read data goes out of a flip-flop, one clock after the select
    always @(posedge mclk) begin
        if (rst) begin
            rd_data <= `TRW_HOLD_RESET;
        end else if (clk_en) begin
            rd_data <= flat[8*rd_sel +: 8];
        end
    end

endmodule

// ===== hdl/trw_unit.v
// table read / table write unit of an 8-bit core
// assumes: core supplies the Q phase and the instruction word on mclk,
// program memory answers a read one mclk after pm_rd_en, all same domain
//
// How it works
// - read opcode 0000_0000_0000_10nn, nn steps
// - write opcode 0000_0000_0000_11nn, same steps
// - read loads addressed byte into latch
// - write copies latch into holding register
// - pointer is 21 bits, byte addressed
// - pointer bit 0 picks low/high byte
// - pointer low three bits pick holding entry
// - write never changes program memory array
// - read: decode, then Q2 fetch, Q4 latch
// - write: decode, then Q2 latch, Q4 hold
// - no arithmetic status flag is touched
`include "trw_map.vh"

module trw_unit #(
    parameter PTR_W = `TRW_PTR_W
) (
    // clock, reset, enable
    input  wire             mclk,
    input  wire             rst,
    input  wire             clk_en,
    // instruction decode from the core
    input  wire [1:0]       q_phase,
    input  wire             instr_valid,
    input  wire [15:0]      instr_word,
    // core access to pointer and latch
    input  wire             ptr_wr_en,
    input  wire [PTR_W-1:0] ptr_wr_data,
    input  wire             latch_wr_en,
    input  wire [7:0]       latch_wr_data,
    // program memory read port
    output wire             pm_rd_en,
    output wire [PTR_W-2:0] pm_word_addr,
    input  wire [15:0]      pm_rdata,
    // holding register read port for the programming sequencer
    input  wire [2:0]       hold_rd_sel,
    output wire [7:0]       hold_rd_data,
    // state seen by the core
    output wire [PTR_W-1:0] byte_pointer,
    output wire [7:0]       table_latch,
    output wire             busy,
    output reg              op_done
);

    // ****************************************
    // states
    // ****************************************
    localparam ST_IDLE   = 2'h0;
    localparam ST_DECODE = 2'h1;
    localparam ST_EXEC   = 2'h2;

    reg  [1:0]       state_reg;
    reg  [1:0]       state_next;
    reg              is_write_reg;
    reg  [1:0]       step_reg;
    reg  [PTR_W-1:0] ptr_reg;
    reg  [PTR_W-1:0] ptr_next;
    reg  [7:0]       latch_reg;
    reg  [7:0]       rd_byte_reg;
    reg  [7:0]       wr_byte_reg;

    wire             is_rd_op;
    wire             is_wr_op;
    wire             start;
    wire             at_q2;
    wire             at_q3;
    wire             at_q4;
    wire             hold_we;
    wire [PTR_W-1:0] ptr_inc;
    wire [PTR_W-1:0] ptr_dec;

    // ****************************************
    // opcode decode
    // ****************************************
    // top fourteen bits fixed, low two bits are the step mode field
    assign is_rd_op = (instr_word[15:2] == `TRW_OPC_RD_HI);
    assign is_wr_op = (instr_word[15:2] == `TRW_OPC_WR_HI);
    assign start    = instr_valid && (q_phase == `TRW_Q1) && (is_rd_op || is_wr_op);

    assign at_q2 = (q_phase == `TRW_Q2);
    assign at_q3 = (q_phase == `TRW_Q3);
    assign at_q4 = (q_phase == `TRW_Q4);

    // ****************************************
    // sequence over two instruction cycles
    // ****************************************
    // first cycle decodes and applies a pre-increment at Q4, second one moves the byte
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    state_next = ST_DECODE;
                end
            end
            ST_DECODE: begin
                if (at_q4) begin
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (at_q4) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // state register and captured opcode fields
    always @(posedge mclk) begin
        if (rst) begin
            state_reg    <= ST_IDLE;
            is_write_reg <= 1'b0;
            step_reg     <= `TRW_STEP_NONE;
        end else if (clk_en) begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE && start) begin
                is_write_reg <= is_wr_op;
                step_reg     <= instr_word[1:0];
            end
        end
    end

    // ****************************************
    // byte pointer
    // ****************************************
    // 21-bit arithmetic drops the carry, so the ends wrap
    assign ptr_inc = ptr_reg + {{(PTR_W-1){1'b0}}, 1'b1};
    assign ptr_dec = ptr_reg - {{(PTR_W-1){1'b0}}, 1'b1};

    // pre-increment lands at decode Q4, post steps at exec Q4
    always @* begin
        ptr_next = ptr_reg;
        if (state_reg == ST_IDLE) begin
            if (ptr_wr_en) begin
                ptr_next = ptr_wr_data;
            end
        end else if (state_reg == ST_DECODE) begin
            if (at_q4 && step_reg == `TRW_STEP_PRE_INC) begin
                ptr_next = ptr_inc;
            end
        end else if (state_reg == ST_EXEC && at_q4) begin
            case (step_reg)
                `TRW_STEP_POST_INC: ptr_next = ptr_inc;
                `TRW_STEP_POST_DEC: ptr_next = ptr_dec;
                default:            ptr_next = ptr_reg;
            endcase
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            ptr_reg <= `TRW_PTR_RESET;
        end else if (clk_en) begin
            ptr_reg <= ptr_next;
        end
    end

    // ****************************************
    // program memory read path
    // ****************************************
    // word address is the pointer without its byte bit
    assign pm_word_addr = ptr_reg[PTR_W-1:1];
    assign pm_rd_en     = (state_reg == ST_EXEC) && at_q2 && !is_write_reg;

    // memory answers one clock later, at Q3; bit 0 picks the byte
    always @(posedge mclk) begin
        if (rst) begin
            rd_byte_reg <= 8'h00;
        end else if (clk_en && state_reg == ST_EXEC && at_q3 && !is_write_reg) begin
            rd_byte_reg <= ptr_reg[0] ? pm_rdata[15:8] : pm_rdata[7:0];
        end
    end

    // ****************************************
    // table latch
    // ****************************************
    // core writes are taken only while idle; table read loads at exec Q4
    always @(posedge mclk) begin
        if (rst) begin
            latch_reg <= `TRW_LATCH_RESET;
        end else if (clk_en) begin
            if (state_reg == ST_EXEC && at_q4 && !is_write_reg) begin
                latch_reg <= rd_byte_reg;
            end else if (state_reg == ST_IDLE && latch_wr_en) begin
                latch_reg <= latch_wr_data;
            end
        end
    end

    // ****************************************
    // table write path
    // ****************************************
    // latch sampled at Q2, holding entry written at Q4
    always @(posedge mclk) begin
        if (rst) begin
            wr_byte_reg <= `TRW_LATCH_RESET;
        end else if (clk_en && state_reg == ST_EXEC && at_q2 && is_write_reg) begin
            wr_byte_reg <= latch_reg;
        end
    end

    assign hold_we = (state_reg == ST_EXEC) && at_q4 && is_write_reg;

    // holding bank has no path to the memory array: staging only
    trw_hold_bank #(
        .DEPTH (`TRW_HOLD_DEPTH),
        .SEL_W (`TRW_HOLD_SEL_W)
    ) u_hold (
        .mclk    (mclk),
        .rst     (rst),
        .clk_en  (clk_en),
        .wr_en   (hold_we),
        .wr_sel  (ptr_reg[2:0]),
        .wr_data (wr_byte_reg),
        .rd_sel  (hold_rd_sel),
        .rd_data (hold_rd_data)
    );

    // ****************************************
    // completion and status
    // ****************************************
    // one-clock pulse in the clock after exec Q4; carry, zero and negative are never driven here
    always @(posedge mclk) begin
        if (rst) begin
            op_done <= 1'b0;
        end else if (clk_en) begin
            op_done <= (state_reg == ST_EXEC) && at_q4;
        end
    end

    assign busy         = (state_reg != ST_IDLE);
    assign byte_pointer = ptr_reg;
    assign table_latch  = latch_reg;

endmodule
